// ---- hdl/pnrp_host.sv ----
`timescale 1ns/1ps
`include "pnrp_cfg.svh"
// Host controller: reads bytes and runs the byte-program sequence.
module pnrp_host #(
  parameter int ADDR_W = `PNRP_ADDR_W,
  parameter int DATA_W = `PNRP_DATA_W,
  parameter int PROG_CYC = `PNRP_PROG_CYC,
  parameter logic WP_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // User side
  input wire logic rd_req_i,
  input wire logic prog_req_i,
  input wire logic reset_req_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic error_o,
  output logic [DATA_W-1:0] rdata_o,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0] data_bus_o,
  output logic data_bus_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic wp_n_o,
  output logic rst_n_o
);
  pnrp_pkg::pnrp_state_t st_r, st_nxt;
  logic [1:0] step_r, step_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic is_prog_r, is_prog_nxt;
  logic [ADDR_W-1:0] tgt_a_r, tgt_a_nxt;
  logic [DATA_W-1:0] tgt_d_r, tgt_d_nxt;
  logic [DATA_W-1:0] prev_r, prev_nxt;
  logic busy_nxt, done_nxt, error_nxt, rst_n_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata, cyc_rdata;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Address and data of each of the four program writes
  function automatic logic [ADDR_W-1:0] step_addr(input logic [1:0] s,
      input logic [ADDR_W-1:0] tgt);
    case (s)
      2'h0: step_addr = ADDR_W'(`PNRP_UNLOCK_A1);
      2'h1: step_addr = ADDR_W'(`PNRP_UNLOCK_A2);
      2'h2: step_addr = ADDR_W'(`PNRP_UNLOCK_A3);
      default: step_addr = tgt;
    endcase
  endfunction : step_addr

  function automatic logic [DATA_W-1:0] step_data(input logic [1:0] s,
      input logic [DATA_W-1:0] tgt);
    case (s)
      2'h0: step_data = DATA_W'(`PNRP_UNLOCK_D1);
      2'h1: step_data = DATA_W'(`PNRP_UNLOCK_D2);
      2'h2: step_data = DATA_W'(`PNRP_UNLOCK_D3);
      default: step_data = tgt;
    endcase
  endfunction : step_data

  // Two status reads agree when bit six did not toggle
  function automatic logic stable(input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b);
    stable = (a[`PNRP_TOGGLE_BIT] == b[`PNRP_TOGGLE_BIT]);
  endfunction : stable

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // New user requests are refused while busy, so no command ever
  // reaches the flash during internal programming (R16)
  always_comb begin
    st_nxt = st_r;
    step_nxt = step_r;
    tmo_nxt = tmo_r;
    rcnt_nxt = rcnt_r;
    is_prog_nxt = is_prog_r;
    tgt_a_nxt = tgt_a_r;
    tgt_d_nxt = tgt_d_r;
    prev_nxt = prev_r;
    busy_nxt = busy_o;
    done_nxt = 1'b0;
    error_nxt = 1'b0;
    rdata_nxt = rdata_o;
    rst_n_nxt = 1'b1;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = tgt_a_r;
    cyc_wdata = tgt_d_r;
    case (st_r)
      pnrp_pkg::PNRP_IDLE: begin
        busy_nxt = 1'b0;
        if (reset_req_i) begin
          rcnt_nxt = 3'(`PNRP_RST_CYC);
          busy_nxt = 1'b1;
          st_nxt = pnrp_pkg::PNRP_RESET; // R19
        end else if (prog_req_i) begin
          // No erase path here: the caller must target an erased byte
          tgt_a_nxt = addr_i; // R11
          tgt_d_nxt = wdata_i;
          step_nxt = 2'h0;
          is_prog_nxt = 1'b1;
          busy_nxt = 1'b1;
          st_nxt = pnrp_pkg::PNRP_WR_CYC; // R12
        end else if (rd_req_i) begin
          tgt_a_nxt = addr_i;
          is_prog_nxt = 1'b0;
          // A finished program leaves the poll count set; clear it so the
          // read engine is started again
          rcnt_nxt = 3'h0;
          busy_nxt = 1'b1;
          st_nxt = pnrp_pkg::PNRP_RD;
        end
      end
      pnrp_pkg::PNRP_WR_CYC: begin
        // Fixed unlock order; a broken order would abort at the flash
        cyc_start = 1'b1; // R12
        cyc_write = 1'b1;
        cyc_addr = step_addr(step_r, tgt_a_r);
        cyc_wdata = step_data(step_r, tgt_d_r);
        st_nxt = pnrp_pkg::PNRP_WR_GAP;
      end
      pnrp_pkg::PNRP_WR_GAP: begin
        if (cyc_done) begin
          if (step_r == 2'h3) begin
            // Fourth strobe rose: programming runs, status polling valid
            tmo_nxt = 32'(PROG_CYC); // R13 R24
            prev_nxt = '0;
            rcnt_nxt = 3'h0;
            st_nxt = pnrp_pkg::PNRP_POLL;
          end else begin
            step_nxt = step_r + 2'h1;
            st_nxt = pnrp_pkg::PNRP_WR_CYC;
          end
        end
      end
      pnrp_pkg::PNRP_POLL: begin
        // Poll the target address; status only, no array data (R15)
        cyc_start = 1'b1;
        st_nxt = pnrp_pkg::PNRP_RD;
      end
      pnrp_pkg::PNRP_RD: begin
        if (tmo_r != 32'h0) begin
          tmo_nxt = tmo_r - 32'h1;
        end
        if (!is_prog_r) begin
          cyc_start = (rcnt_r == 3'h0);
          rcnt_nxt = 3'h1;
          if (cyc_done) begin
            rdata_nxt = cyc_rdata; // R8
            rcnt_nxt = 3'h0;
            done_nxt = 1'b1;
            st_nxt = pnrp_pkg::PNRP_DONE;
          end
        end else if (cyc_done) begin
          prev_nxt = cyc_rdata;
          // Saturate so a long poll never wraps back to the first-poll mark
          rcnt_nxt = (rcnt_r == 3'h7) ? rcnt_r : rcnt_r + 3'h1;
          // Done when bit seven is true and bit six stopped toggling
          if (cyc_rdata[`PNRP_POLL_BIT] == tgt_d_r[`PNRP_POLL_BIT] &&
              rcnt_r != 3'h0 && stable(cyc_rdata, prev_r)) begin // R22 R23
            rdata_nxt = cyc_rdata;
            done_nxt = 1'b1;
            st_nxt = pnrp_pkg::PNRP_DONE;
          end else if (tmo_r == 32'h0) begin
            // Longer than the bound: flag and reset the flash
            error_nxt = 1'b1; // R14
            rcnt_nxt = 3'(`PNRP_RST_CYC);
            st_nxt = pnrp_pkg::PNRP_RESET;
          end else begin
            st_nxt = pnrp_pkg::PNRP_POLL;
          end
        end
      end
      pnrp_pkg::PNRP_RESET: begin
        rst_n_nxt = 1'b0; // R19
        rcnt_nxt = rcnt_r - 3'h1;
        if (rcnt_r == 3'h1) begin
          done_nxt = 1'b1;
          st_nxt = pnrp_pkg::PNRP_DONE;
        end
      end
      default: begin
        busy_nxt = 1'b0;
        st_nxt = pnrp_pkg::PNRP_IDLE;
      end
    endcase
  end

  // Registers; write protect is low in reset, then the constant WP_LEVEL (R17)
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= pnrp_pkg::PNRP_IDLE;
      step_r <= 2'h0;
      tmo_r <= 32'h0;
      rcnt_r <= 3'h0;
      is_prog_r <= 1'b0;
      tgt_a_r <= '0;
      tgt_d_r <= '0;
      prev_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      rdata_o <= '0;
      rst_n_o <= 1'b0;
      wp_n_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      step_r <= step_nxt;
      tmo_r <= tmo_nxt;
      rcnt_r <= rcnt_nxt;
      is_prog_r <= is_prog_nxt;
      tgt_a_r <= tgt_a_nxt;
      tgt_d_r <= tgt_d_nxt;
      prev_r <= prev_nxt;
      busy_o <= busy_nxt;
      done_o <= done_nxt;
      error_o <= error_nxt;
      rdata_o <= rdata_nxt;
      rst_n_o <= rst_n_nxt;
      wp_n_o <= WP_LEVEL; // R17
    end
  end

  // ------------------------------------------------------------------
  // Pin cycle engine
  // ------------------------------------------------------------------
  pnrp_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .PULSE_CYC(`PNRP_STROBE_CYC)
  ) u_cycle (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .addr_i(cyc_addr),
    .wdata_i(cyc_wdata),
    .dq_i(data_bus_i),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(flash_addr_o),
    .dq_o(data_bus_o),
    .dq_oe_o(data_bus_oe_o),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o)
  );
endmodule : pnrp_host

// ---- hdl/pnrp_cfg.svh ----
// Contract
// R1 - Flash holds 2M bytes: 21 address lines, one 8-bit data bus.
// R2 - Host writes a command by pulsing write strobe low with select low.
// R3 - Device captures address on the later falling edge of strobe or select.
// R4 - Device captures data on the earlier rising edge of strobe or select.
// R5 - Device drops to low power by itself after a completed read.
// R6 - Any address or control change starting a read wakes it, no delay.
// R7 - After power-up with select low, no low power until first change.
// R8 - Device drives data only when select and output enable are both low; the flash model drives the inverse of its last byte otherwise.
// R9 - Data bus floats whenever select or output enable is high; the flash model drives the inverse of its last byte instead.
// R10 - Select high deselects the device; bus activity is ignored.
// R11 - Host programs a byte only into an already erased sector.
// R12 - Byte program is three unlock writes then one address and data write.
// R13 - Internal programming starts at the earlier rising edge of fourth write.
// R14 - Internal programming finishes within 10 us, then reads are normal.
// R15 - While programming, reads return only status bits, not array data.
// R16 - Device ignores commands written while programming runs.
// R17 - Host holds write protect constant throughout a command sequence.
// R18 - With write protect grounded, boot block program and erase refused.
// R19 - Asserting reset aborts activity and returns the device to read mode.
// R20 - Sector uses address bits 20 to 12; block uses bits 20 to 16.
// R21 - A write off the expected sequence step abandons it, no programming.
// R22 - While busy, bit seven reads inverted; true once programming is done.
// R23 - While busy, bit six alternates on consecutive reads; stops when done.
// R24 - Inverted bit seven is valid after the fourth write's rising edge.
`ifndef PNRP_CFG_SVH
`define PNRP_CFG_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define PNRP_ADDR_W 21
`define PNRP_DATA_W 8
`define PNRP_SECTOR_LSB 12
`define PNRP_BLOCK_LSB 16
`define PNRP_POLL_BIT 7
`define PNRP_TOGGLE_BIT 6

// ----------------------------------------------------------------------
// Unlock sequence (addresses and data of the three unlock writes)
// ----------------------------------------------------------------------
`define PNRP_UNLOCK_A1 21'h000555
`define PNRP_UNLOCK_D1 8'haa
`define PNRP_UNLOCK_A2 21'h0002aa
`define PNRP_UNLOCK_D2 8'h55
`define PNRP_UNLOCK_A3 21'h000555
`define PNRP_UNLOCK_D3 8'ha0

// ----------------------------------------------------------------------
// Timing, 100 MHz clock
// ----------------------------------------------------------------------
`define PNRP_CLK_NS 10
`define PNRP_PROG_MAX_NS 10000
`define PNRP_PROG_CYC (`PNRP_PROG_MAX_NS / `PNRP_CLK_NS)
`define PNRP_STROBE_CYC 4
`define PNRP_RST_CYC 4

`endif

// ---- hdl/pnrp_pkg.sv ----
package pnrp_pkg;
  // Top-level sequencer states, Gray coded along the program path
  typedef enum logic [3:0] {
    PNRP_IDLE = 4'h0,
    PNRP_WR_CYC = 4'h1,
    PNRP_WR_GAP = 4'h3,
    PNRP_POLL = 4'h2,
    PNRP_RD = 4'h6,
    PNRP_DONE = 4'h7,
    PNRP_RESET = 4'h5
  } pnrp_state_t;

  // Bus cycle engine states
  typedef enum logic [1:0] {
    PNRP_CYC_IDLE = 2'h0,
    PNRP_CYC_SETUP = 2'h1,
    PNRP_CYC_PULSE = 2'h3,
    PNRP_CYC_HOLD = 2'h2
  } pnrp_cyc_t;
endpackage : pnrp_pkg

// ---- hdl/pnrp_cycle.sv ----
`timescale 1ns/1ps
`include "pnrp_cfg.svh"
// One pin-level bus cycle: write (select and strobe low) or read.
module pnrp_cycle #(
  parameter int ADDR_W = `PNRP_ADDR_W,
  parameter int DATA_W = `PNRP_DATA_W,
  parameter int PULSE_CYC = `PNRP_STROBE_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);
  pnrp_pkg::pnrp_cyc_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] dq_nxt;
  logic dq_oe_nxt, ce_n_nxt, oe_n_nxt, we_n_nxt;

  // ------------------------------------------------------------------
  // Cycle sequencing
  // ------------------------------------------------------------------
  // Address set up before strobe falls and held past its rise, so both
  // capture edges of the device see stable pins
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_o;
    addr_nxt = addr_o;
    dq_nxt = dq_o;
    dq_oe_nxt = dq_oe_o;
    ce_n_nxt = ce_n_o;
    oe_n_nxt = oe_n_o;
    we_n_nxt = we_n_o;
    case (st_r)
      pnrp_pkg::PNRP_CYC_IDLE: begin
        if (start_i) begin
          addr_nxt = addr_i;
          wr_nxt = write_i;
          dq_nxt = wdata_i;
          dq_oe_nxt = write_i; // R9
          ce_n_nxt = 1'b0;
          st_nxt = pnrp_pkg::PNRP_CYC_SETUP;
        end
      end
      pnrp_pkg::PNRP_CYC_SETUP: begin
        // Strobe falls after select: address taken here on write, R3
        we_n_nxt = ~wr_r; // R2
        oe_n_nxt = wr_r; // R8
        cnt_nxt = 8'(PULSE_CYC);
        st_nxt = pnrp_pkg::PNRP_CYC_PULSE;
      end
      pnrp_pkg::PNRP_CYC_PULSE: begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          // Strobe rises before select: data taken here, R4
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          rdata_nxt = dq_i;
          st_nxt = pnrp_pkg::PNRP_CYC_HOLD;
        end
      end
      default: begin
        ce_n_nxt = 1'b1; // R10
        dq_oe_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = pnrp_pkg::PNRP_CYC_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= pnrp_pkg::PNRP_CYC_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= '0;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done_o <= done_nxt;
      rdata_o <= rdata_nxt;
      addr_o <= addr_nxt;
      dq_o <= dq_nxt;
      dq_oe_o <= dq_oe_nxt;
      ce_n_o <= ce_n_nxt;
      oe_n_o <= oe_n_nxt;
      we_n_o <= we_n_nxt;
    end
  end
endmodule : pnrp_cycle

// ---- testbench/pnrp_host_properties.sv ----
`timescale 1ns/1ps
`include "pnrp_cfg.svh"
// ----------------------------------------------------------
// Pin protocol checks on the host controller
// ----------------------------------------------------------
module pnrp_host_properties #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 8,
  parameter logic WP_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] data_bus_o,
  input wire logic data_bus_oe_o,
  input wire logic ce_n_o,
  input wire logic oe_n_o,
  input wire logic we_n_o,
  input wire logic wp_n_o,
  input wire logic rst_n_o
);
  logic we_q;
  logic fall;
  logic [2:0] wcnt;
  logic [2:0] wcnt_nxt;
  logic [ADDR_W-1:0] ua;
  logic [DATA_W-1:0] ud;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // Strobe falls counted per busy period; idle clears the count
  always_comb begin
    fall = we_q && !we_n_o;
    wcnt_nxt = !busy_o ? 3'h0 : wcnt + {2'h0, fall};
    ua = (wcnt == 3'h1) ? `PNRP_UNLOCK_A2 : `PNRP_UNLOCK_A1;
    ud = (wcnt == 3'h0) ? `PNRP_UNLOCK_D1 :
         (wcnt == 3'h1) ? `PNRP_UNLOCK_D2 : `PNRP_UNLOCK_D3;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      we_q <= 1'b1;
      wcnt <= 3'h0;
    end else begin
      we_q <= we_n_o;
      wcnt <= wcnt_nxt;
    end
  end

  we_under_ce_a: assert property (
    !we_n_o |-> !ce_n_o && oe_n_o) else $error("strobe outside select");
  strobe_width_a: assert property (
    $fell(we_n_o) |-> (!we_n_o) [*4] ##1 we_n_o)
    else $error("write strobe width wrong");
  wdata_hold_a: assert property (
    !we_n_o |-> data_bus_oe_o && $stable(flash_addr_o)
    && $stable(data_bus_o)) else $error("write lines moved");
  bus_turn_a: assert property (
    !oe_n_o |-> !data_bus_oe_o) else $error("host drives during read");
  wp_steady_a: assert property (
    busy_o |-> wp_n_o == WP_LEVEL && $stable(wp_n_o))
    else $error("write protect moved");
  unlock_order_a: assert property (
    fall && wcnt < 3'h3 |-> flash_addr_o == ua && data_bus_o == ud)
    else $error("unlock write wrong");
  write_count_a: assert property (
    done_o |-> wcnt == 3'h0 || wcnt == 3'h4)
    else $error("wrong number of writes");
  reset_pulse_a: assert property (
    $fell(rst_n_o) |-> (!rst_n_o) [*4] ##1 rst_n_o)
    else $error("reset pulse width wrong");
endmodule : pnrp_host_properties

bind pnrp_host pnrp_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .WP_LEVEL(WP_LEVEL)) u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .busy_o(busy_o), .done_o(done_o), .flash_addr_o(flash_addr_o),
  .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o),
  .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .wp_n_o(wp_n_o),
  .rst_n_o(rst_n_o));

// ---- testbench/pnrp_flash_model.sv ----
`timescale 1ns/1ps
`include "pnrp_cfg.svh"
// ----------------------------------------------------------
// Behavioural byte-wide flash, driven by pin edges only
// ----------------------------------------------------------
module pnrp_flash_model (
  input wire logic [20:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic wp_n_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [logic [20:0]];
  logic [20:0] a_q;
  logic [7:0] tgt = 8'h00;
  logic [7:0] rd_q = 8'h5a;
  logic [1:0] step = 2'h0;
  logic tog = 1'b0;
  realtime end_t = 0;

  function automatic logic [7:0] rdm(input logic [20:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rdm

  // Unwritten cells stay erased, so the host never programs dirty bytes
  task automatic wr(input logic [20:0] a, input logic [7:0] d);
    if (step == 2'h3) begin
      step = 2'h0;
      if (wp_n_i || (a[20:16] != 5'h00 && a[20:16] != 5'h1f)) begin
        mem[a] = rdm(a) & d;
        tgt = d;
        end_t = $realtime + (slow_i ? 3000 : 300);
      end
    end else if (a == (step == 2'h1 ? `PNRP_UNLOCK_A2 : `PNRP_UNLOCK_A1)
      && d == (step == 2'h0 ? `PNRP_UNLOCK_D1 : step == 2'h1 ?
      `PNRP_UNLOCK_D2 : `PNRP_UNLOCK_D3)) begin
      step = step + 2'h1;
    end else begin
      step = 2'h0;
    end
  endtask : wr

  // Address taken when the later of strobe and select falls
  always @(negedge we_n_i or negedge ce_n_i) begin
    if (!we_n_i && !ce_n_i) a_q = addr_i;
  end

  // Data taken at the earlier rising edge; busy swallows commands
  always @(posedge we_n_i or posedge ce_n_i) begin
    if (ce_n_i != we_n_i && rst_n_i && $realtime >= end_t) begin
      wr(a_q, dq_i);
    end
  end

  // No power state kept: each new read is served at once
  always @(negedge oe_n_i or negedge ce_n_i or addr_i) begin
    if (!ce_n_i && !oe_n_i) begin
      if ($realtime < end_t) begin
        rd_q = {~tgt[7], tog, rd_q[5:0]};
        tog = ~tog;
      end else begin
        rd_q = rdm(addr_i);
      end
    end
  end

  always @(negedge rst_n_i) begin
    step = 2'h0;
    end_t = 0;
  end

  // Released bus shows the inverse of the last byte, not a held value
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_q : ~rd_q;
endmodule : pnrp_flash_model

// ---- testbench/parallel_nor_read_program_tb.sv ----
`timescale 1ns/1ps
module parallel_nor_read_program_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic rd_req_i = 1'b0;
  logic prog_req_i = 1'b0;
  logic reset_req_i = 1'b0;
  logic [20:0] addr_i = 21'h000000;
  logic [7:0] wdata_i = 8'h00;
  logic slow = 1'b0;
  logic busy_o, done_o, error_o, data_bus_oe_o, ce_n_o, oe_n_o, we_n_o;
  logic wp_n_o, rst_n_o, got_err, got_rst;
  logic [7:0] rdata_o, data_bus_o, flash_dq, data_bus;
  logic [20:0] flash_addr_o;
  int errors = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;
  // Host drive wins while it writes, the flash lines otherwise
  assign data_bus = data_bus_oe_o ? data_bus_o : flash_dq;

  pnrp_host #(.PROG_CYC(100)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .rd_req_i(rd_req_i), .prog_req_i(prog_req_i),
    .reset_req_i(reset_req_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .done_o(done_o), .error_o(error_o),
    .rdata_o(rdata_o), .flash_addr_o(flash_addr_o), .data_bus_i(data_bus),
    .data_bus_o(data_bus_o), .data_bus_oe_o(data_bus_oe_o),
    .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .wp_n_o(wp_n_o),
    .rst_n_o(rst_n_o));
  pnrp_flash_model u_flash (.addr_i(flash_addr_o), .dq_i(data_bus),
    .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .wp_n_i(wp_n_o),
    .rst_n_i(rst_n_o), .slow_i(slow), .dq_o(flash_dq));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task chk(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One request, held until taken, then waited on up to its done pulse
  task op(input logic r, p, s, input logic [20:0] a, input logic [7:0] d);
    int i;
    logic fin;
    fin = 1'b0;
    got_err = 1'b0;
    got_rst = 1'b0;
    for (i = 0; i < 20 && busy_o !== 1'b0; i++) @(negedge clk_i);
    if (busy_o !== 1'b0) begin
      errors++;
      $display("CHECK FAILED idle expected 0 seen 1");
      test_done();
    end
    @(posedge clk_i);
    rd_req_i <= r;
    prog_req_i <= p;
    reset_req_i <= s;
    addr_i <= a;
    wdata_i <= d;
    for (i = 0; i < 20 && busy_o !== 1'b1; i++) @(negedge clk_i);
    if (busy_o !== 1'b1) begin
      errors++;
      $display("CHECK FAILED busy expected 1 seen 0");
      test_done();
    end
    @(posedge clk_i);
    rd_req_i <= 1'b0;
    prog_req_i <= 1'b0;
    reset_req_i <= 1'b0;
    for (i = 0; i < 3000 && !fin; i++) begin
      @(negedge clk_i);
      got_err = got_err | (error_o === 1'b1);
      got_rst = got_rst | (rst_n_o === 1'b0);
      fin = (done_o === 1'b1);
    end
    if (!fin) begin
      errors++;
      $display("CHECK FAILED done expected 1 seen 0");
      test_done();
    end
  endtask : op

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_idle_pins();
    // No clock edge has seen the release yet: flash still held in reset
    @(negedge clk_i);
    chk("rst held", {7'h00, rst_n_o}, 8'h00);
    @(negedge clk_i);
    chk("wp", {7'h00, wp_n_o}, 8'h01);
    chk("rst", {7'h00, rst_n_o}, 8'h01);
    chk("ce", {7'h00, ce_n_o}, 8'h01);
  endtask : t_idle_pins

  task t_program();
    op(1'b1, 1'b0, 1'b0, 21'h012345, 8'h00);
    chk("blank", rdata_o, 8'hff);
    op(1'b0, 1'b1, 1'b0, 21'h012345, 8'h3c);
    chk("prog err", {7'h00, got_err}, 8'h00);
    chk("prog status", rdata_o, 8'h3c);
    op(1'b1, 1'b0, 1'b0, 21'h012345, 8'h00);
    chk("prog read", rdata_o, 8'h3c);
  endtask : t_program

  // Top address, program and read asked together: program wins
  task t_priority();
    op(1'b1, 1'b1, 1'b0, 21'h1fffff, 8'h0f);
    op(1'b1, 1'b0, 1'b0, 21'h1fffff, 8'h00);
    chk("top read", rdata_o, 8'h0f);
    op(1'b1, 1'b0, 1'b0, 21'h1ffffe, 8'h00);
    chk("neighbour", rdata_o, 8'hff);
  endtask : t_priority

  // A stuck program must time out and pulse the flash reset
  task t_timeout();
    slow <= 1'b1;
    op(1'b0, 1'b1, 1'b0, 21'h0a0000, 8'h11);
    chk("timeout err", {7'h00, got_err}, 8'h01);
    chk("timeout rst", {7'h00, got_rst}, 8'h01);
    slow <= 1'b0;
    op(1'b1, 1'b0, 1'b0, 21'h0a0001, 8'h00);
    chk("after abort", rdata_o, 8'hff);
    op(1'b0, 1'b0, 1'b1, 21'h000000, 8'h00);
    chk("reset req", {7'h00, got_rst}, 8'h01);
  endtask : t_timeout

  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_idle_pins();
    t_program();
    t_priority();
    t_timeout();
    test_done();
  end
endmodule : parallel_nor_read_program_tb
